// ==== inc/mpfc_pkg.sv ====
package mpfc_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_TX_CHANNEL = 8'h02;
   localparam logic [7:0] IDX_TX_CONTROL = 8'h03;
   localparam logic [7:0] IDX_RX_CHANNEL = 8'h04;
   localparam logic [7:0] IDX_RX_CONTROL = 8'h05;
   localparam logic [7:0] IDX_TONE_PTR = 8'h0c;
   localparam logic [7:0] IDX_TONE_DATA = 8'h0d;
   localparam logic [7:0] IDX_RX_HDR_STAT = 8'h10;
   localparam logic [7:0] IDX_FRAME_STAT = 8'h11;
   localparam logic [7:0] IDX_BURST_CTL = 8'h12;

   localparam logic [7:0] TX_CHANNEL_RST = 8'h00;
   localparam logic [7:0] TX_CONTROL_RST = 8'h00;
   localparam logic [7:0] RX_CHANNEL_RST = 8'h00;
   localparam logic [7:0] RX_CONTROL_RST = 8'h00;
   localparam logic [5:0] TONE_PTR_RST = 6'h00;
   localparam logic [7:0] TONE_NULL_RST = 8'hff;

   // writable bits; reserved bits read zero
   localparam logic [7:0] CHANNEL_MASK = 8'h7f;
   localparam logic [7:0] TX_CONTROL_MASK = 8'hfd;
   localparam logic [7:0] RX_CONTROL_MASK = 8'h0f;

   localparam int CTL_PT_BIT = 0;
   localparam int RX_HEADER_PT_PROCESSING_BIT = 1;
   localparam int PTR_RESET_BIT = 6;
   localparam int AXI_IDX_LSB = 2;

   localparam logic [5:0] TONE_PTR_LAST = 6'h2f;
   localparam logic [5:0] TONE_ENTRIES = 6'h30;
   localparam logic [1:0] BAND_ALL = 2'h3;

   // longest setup or hold window, in link clock periods
   localparam logic [7:0] PARAM_WINDOW_MAX = 8'h80;

   localparam logic [4:0] RATE_LOWEST = 5'h00;
   localparam logic [4:0] RATE_TOP_CC = 5'h0b;
   localparam logic [4:0] RATE_RSV_LO = 5'h0c;
   localparam logic [4:0] RATE_RSV_HI = 5'h12;
   localparam logic [4:0] RATE_LDPC_RSV_LO = 5'h18;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [1:0] {
      RX_OFF = 2'b01,
      RX_ON = 2'b10
   } mpfc_rx_e;

   typedef struct packed {
      logic [7:0] channel;
      logic [7:0] control;
   } mpfc_tx_param_s;

   typedef struct packed {
      logic [7:0] channel;
      logic [7:0] control;
      logic preamble;
   } mpfc_rx_param_s;

   typedef struct packed {
      logic valid;
      logic burst;
      logic preamble;
      logic [4:0] rate;
   } mpfc_rx_hdr_s;

endpackage

// ==== core/mpfc_tone_map.sv ====
`timescale 1ns/1ns
module mpfc_tone_map (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [5:0] wr_idx,
   input wire logic [7:0] wr_data,
   input wire logic clr_en,
   input wire logic [1:0] clr_band,
   input wire logic [5:0] rd_idx,
   output logic [7:0] rd_data,
   input wire logic [5:0] dp_idx,
   output logic [7:0] dp_mask
);

   // bit n of an entry is subcarrier 8*addr-64+n, lowest first; 0 nulls it
   logic [7:0] map [48];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 48; i++) begin
            map[i] <= mpfc_pkg::TONE_NULL_RST;
         end
      end else if (clr_en) begin
         for (int i = 0; i < 48; i++) begin
            if (clr_band == mpfc_pkg::BAND_ALL || i[5:4] == clr_band) begin
               map[i] <= mpfc_pkg::TONE_NULL_RST;
            end
         end
      end else if (wr_en && wr_idx < mpfc_pkg::TONE_ENTRIES) begin
         map[wr_idx] <= wr_data;
      end
   end

   always_comb begin
      rd_data = mpfc_pkg::TONE_NULL_RST;
      if (rd_idx < mpfc_pkg::TONE_ENTRIES) begin
         rd_data = map[rd_idx];
      end
   end

   // out-of-range band reads as all active
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dp_mask <= mpfc_pkg::TONE_NULL_RST;
      end else if (dp_idx < mpfc_pkg::TONE_ENTRIES) begin
         dp_mask <= map[dp_idx];
      end else begin
         dp_mask <= mpfc_pkg::TONE_NULL_RST;
      end
   end

endmodule

// ==== core/mpfc_frame_param_ctrl.sv ====
`timescale 1ns/1ns
module mpfc_frame_param_ctrl (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic [11:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [11:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic PCLK,
   input wire logic TX_EN,
   input wire logic RX_EN,
   input wire logic PHY_ACTIVITY_IND,
   input wire mpfc_pkg::mpfc_rx_hdr_s RX_HDR,
   output mpfc_pkg::mpfc_tx_param_s TX_PARAM,
   output mpfc_pkg::mpfc_rx_param_s RX_PARAM,
   input wire logic [5:0] TONE_IDX,
   output logic [7:0] TONE_MASK
);

   function automatic logic [5:0] tone_ptr_inc(input logic [5:0] p);
      if (p == mpfc_pkg::TONE_PTR_LAST) begin
         return 6'h00;
      end
      return p + 6'h01;
   endfunction

   function automatic logic reg_known(input logic [7:0] idx);
      case (idx)
         mpfc_pkg::IDX_TX_CHANNEL,
         mpfc_pkg::IDX_TX_CONTROL,
         mpfc_pkg::IDX_RX_CHANNEL,
         mpfc_pkg::IDX_RX_CONTROL,
         mpfc_pkg::IDX_TONE_PTR,
         mpfc_pkg::IDX_TONE_DATA,
         mpfc_pkg::IDX_RX_HDR_STAT,
         mpfc_pkg::IDX_FRAME_STAT,
         mpfc_pkg::IDX_BURST_CTL: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic rate_reserved(input logic [4:0] r);
      return (r >= mpfc_pkg::RATE_RSV_LO && r <= mpfc_pkg::RATE_RSV_HI) ||
             r >= mpfc_pkg::RATE_LDPC_RSV_LO;
   endfunction

   // link-side inputs
   logic pclk_q1, pclk_q2, pclk_q3;
   logic tx_en_q1, tx_en_q2, rx_en_q1, rx_en_q2;
   logic tx_en_pc, rx_en_pc, active_q;

   // software registers
   logic [7:0] tx_channel_sel, tx_frame_control, rx_channel_sel, rx_frame_control;
   logic [5:0] tone_map_pointer;
   logic burst_en;

   // last received header
   logic hdr_burst, hdr_preamble;
   logic [4:0] hdr_rate;

   mpfc_pkg::mpfc_rx_e rx_state;

   // bus side
   logic aw_held, w_held, w_lane0, wr_fire, rd_fire;
   logic [7:0] aw_idx, w_byte, ar_idx, tone_rd;
   logic [31:0] next_rdata;
   logic tone_wr, tone_clr, tone_rd_hit;

   logic pclk_rise, tx_start, rx_start, active_fall, rx_reload, next_preamble;

   // two flops before any logic looks at PCLK, TX_EN or RX_EN
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         pclk_q1 <= 1'b0;
         pclk_q2 <= 1'b0;
         pclk_q3 <= 1'b0;
         tx_en_q1 <= 1'b0;
         tx_en_q2 <= 1'b0;
         rx_en_q1 <= 1'b0;
         rx_en_q2 <= 1'b0;
      end else begin
         pclk_q1 <= PCLK;
         pclk_q2 <= pclk_q1;
         pclk_q3 <= pclk_q2;
         tx_en_q1 <= TX_EN;
         tx_en_q2 <= tx_en_q1;
         rx_en_q1 <= RX_EN;
         rx_en_q2 <= rx_en_q1;
      end
   end

   assign pclk_rise = pclk_q2 & ~pclk_q3;

   // enables are judged only at link clock edges, as the MAC drives them
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         tx_en_pc <= 1'b0;
         rx_en_pc <= 1'b0;
      end else if (pclk_rise) begin
         tx_en_pc <= tx_en_q2;
         rx_en_pc <= rx_en_q2;
      end
   end

   // activity comes from our own receive path, same clock
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         active_q <= 1'b0;
      end else begin
         active_q <= PHY_ACTIVITY_IND;
      end
   end

   assign tx_start = pclk_rise & tx_en_q2 & ~tx_en_pc;
   assign rx_start = pclk_rise & rx_en_q2 & ~rx_en_pc;
   assign active_fall = active_q & ~PHY_ACTIVITY_IND;
   // a fresh enable in the same cycle wins over the burst reload
   assign rx_reload = active_fall & rx_en_pc & (rx_state == mpfc_pkg::RX_ON) & ~rx_start;

   // capture happens within three system clocks of the link rise, well inside even a one-period hold window
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         TX_PARAM <= '0;
      end else if (tx_start) begin
         TX_PARAM.channel <= tx_channel_sel;
         TX_PARAM.control <= tx_frame_control;
      end
   end

   always_comb begin
      next_preamble = rx_frame_control[mpfc_pkg::CTL_PT_BIT];
      if (burst_en && rx_frame_control[mpfc_pkg::RX_HEADER_PT_PROCESSING_BIT] && hdr_burst) begin
         next_preamble = hdr_preamble;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         RX_PARAM <= '0;
      end else if (rx_start) begin
         RX_PARAM.channel <= rx_channel_sel;
         RX_PARAM.control <= rx_frame_control;
         RX_PARAM.preamble <= rx_frame_control[mpfc_pkg::CTL_PT_BIT];
      end else if (rx_reload) begin
         RX_PARAM.channel <= rx_channel_sel;
         RX_PARAM.control <= rx_frame_control;
         RX_PARAM.preamble <= next_preamble;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         rx_state <= mpfc_pkg::RX_OFF;
      end else begin
         case (rx_state)
            mpfc_pkg::RX_OFF: begin
               if (rx_start) begin
                  rx_state <= mpfc_pkg::RX_ON;
               end
            end
            mpfc_pkg::RX_ON: begin
               if (pclk_rise && !rx_en_q2) begin
                  rx_state <= mpfc_pkg::RX_OFF;
               end
            end
            default: rx_state <= mpfc_pkg::RX_OFF;
         endcase
      end
   end

   // header bits of the frame just received feed the next burst frame
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         hdr_burst <= 1'b0;
         hdr_preamble <= 1'b0;
         hdr_rate <= mpfc_pkg::RATE_LOWEST;
      end else if (RX_HDR.valid) begin
         hdr_burst <= RX_HDR.burst;
         hdr_preamble <= RX_HDR.preamble;
         hdr_rate <= RX_HDR.rate;
      end
   end

   // write channel: address and data taken in either order
   assign S_AXI_AWREADY = ~aw_held & ~S_AXI_BVALID;
   assign S_AXI_WREADY = ~w_held & ~S_AXI_BVALID;
   assign wr_fire = aw_held & w_held & ~S_AXI_BVALID;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         aw_held <= 1'b0;
         aw_idx <= 8'h00;
      end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         aw_held <= 1'b1;
         aw_idx <= S_AXI_AWADDR[9:mpfc_pkg::AXI_IDX_LSB];
      end else if (wr_fire) begin
         aw_held <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         w_held <= 1'b0;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
      end else if (S_AXI_WVALID && S_AXI_WREADY) begin
         w_held <= 1'b1;
         w_byte <= S_AXI_WDATA[7:0];
         w_lane0 <= S_AXI_WSTRB[0];
      end else if (wr_fire) begin
         w_held <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= mpfc_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP <= reg_known(aw_idx) ? mpfc_pkg::RESP_OKAY : mpfc_pkg::RESP_DECERR;
      end else if (S_AXI_BREADY) begin
         S_AXI_BVALID <= 1'b0;
      end
   end

   // writes go straight into the live registers; frames run from shadows
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         tx_channel_sel <= mpfc_pkg::TX_CHANNEL_RST;
         tx_frame_control <= mpfc_pkg::TX_CONTROL_RST;
         rx_channel_sel <= mpfc_pkg::RX_CHANNEL_RST;
         rx_frame_control <= mpfc_pkg::RX_CONTROL_RST;
         burst_en <= 1'b0;
      end else if (wr_fire && w_lane0) begin
         case (aw_idx)
            mpfc_pkg::IDX_TX_CHANNEL: tx_channel_sel <= w_byte & mpfc_pkg::CHANNEL_MASK;
            mpfc_pkg::IDX_TX_CONTROL: tx_frame_control <= w_byte & mpfc_pkg::TX_CONTROL_MASK;
            mpfc_pkg::IDX_RX_CHANNEL: rx_channel_sel <= w_byte & mpfc_pkg::CHANNEL_MASK;
            mpfc_pkg::IDX_RX_CONTROL: rx_frame_control <= w_byte & mpfc_pkg::RX_CONTROL_MASK;
            mpfc_pkg::IDX_BURST_CTL: burst_en <= w_byte[0];
            default: ;
         endcase
      end
   end

   // reads stall while a write completes, so one tone access per cycle
   assign S_AXI_ARREADY = ~S_AXI_RVALID & ~wr_fire;
   assign rd_fire = S_AXI_ARVALID & S_AXI_ARREADY;
   assign ar_idx = S_AXI_ARADDR[9:mpfc_pkg::AXI_IDX_LSB];

   assign tone_wr = wr_fire & w_lane0 & (aw_idx == mpfc_pkg::IDX_TONE_DATA);
   assign tone_clr = wr_fire & w_lane0 & (aw_idx == mpfc_pkg::IDX_TONE_PTR) &
                     w_byte[mpfc_pkg::PTR_RESET_BIT];
   assign tone_rd_hit = rd_fire & (ar_idx == mpfc_pkg::IDX_TONE_DATA);

   // no double buffering: pointer moves at once on every tone data access
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         tone_map_pointer <= mpfc_pkg::TONE_PTR_RST;
      end else if (wr_fire && w_lane0 && aw_idx == mpfc_pkg::IDX_TONE_PTR) begin
         tone_map_pointer <= w_byte[5:0];
      end else if (tone_wr || tone_rd_hit) begin
         tone_map_pointer <= tone_ptr_inc(tone_map_pointer);
      end
   end

   always_comb begin
      next_rdata = 32'h0000_0000;
      case (ar_idx)
         mpfc_pkg::IDX_TX_CHANNEL: next_rdata[7:0] = tx_channel_sel;
         mpfc_pkg::IDX_TX_CONTROL: next_rdata[7:0] = tx_frame_control;
         mpfc_pkg::IDX_RX_CHANNEL: next_rdata[7:0] = rx_channel_sel;
         mpfc_pkg::IDX_RX_CONTROL: next_rdata[7:0] = rx_frame_control;
         mpfc_pkg::IDX_TONE_PTR: next_rdata[5:0] = tone_map_pointer;
         mpfc_pkg::IDX_TONE_DATA: next_rdata[7:0] = tone_rd;
         mpfc_pkg::IDX_RX_HDR_STAT: begin
            next_rdata[4:0] = hdr_rate;
            next_rdata[5] = hdr_preamble;
            next_rdata[6] = hdr_burst;
            next_rdata[7] = rate_reserved(hdr_rate);
         end
         mpfc_pkg::IDX_FRAME_STAT: begin
            next_rdata[7:0] = TX_PARAM.control;
            next_rdata[15:8] = RX_PARAM.control;
            next_rdata[16] = RX_PARAM.preamble;
            next_rdata[17] = (rx_state == mpfc_pkg::RX_ON);
         end
         mpfc_pkg::IDX_BURST_CTL: next_rdata[0] = burst_en;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= mpfc_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= next_rdata;
         S_AXI_RRESP <= reg_known(ar_idx) ? mpfc_pkg::RESP_OKAY : mpfc_pkg::RESP_DECERR;
      end else if (S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end

   mpfc_tone_map i_mpfc_tone_map (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .wr_en(tone_wr),
      .wr_idx(tone_map_pointer),
      .wr_data(w_byte),
      .clr_en(tone_clr),
      .clr_band(w_byte[5:4]),
      .rd_idx(tone_map_pointer),
      .rd_data(tone_rd),
      .dp_idx(TONE_IDX),
      .dp_mask(TONE_MASK)
   );

endmodule

// ==== tb/mpfc_frame_param_ctrl_checker.sv ====
`timescale 1ns/1ns
module mpfc_checker (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic TX_EN,
   input wire logic RX_EN,
   input wire logic PHY_ACTIVITY_IND,
   input wire mpfc_pkg::mpfc_tx_param_s TX_PARAM,
   input wire mpfc_pkg::mpfc_rx_param_s RX_PARAM,
   input wire logic [5:0] TONE_IDX,
   input wire logic [7:0] TONE_MASK
);
   logic [4:0] up;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   // an enable held across reset is captured afresh, so hold checks wait
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) up <= 5'h00;
      else if (up != 5'h1f) up <= up + 5'h01;
   end
   AST_WR_RESP: assert property (
      S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
      else $error("write response late");
   AST_WR_BLOCK: assert property (
      S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write taken while response pending");
   AST_RD_RESP: assert property (
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read data late");
   AST_RD_DONE: assert property (
      S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
      else $error("read data not released");
   AST_TONE_OOR: assert property (
      TONE_IDX > 6'h2f |=> TONE_MASK == 8'hff)
      else $error("tone entry beyond map not all ones");
   AST_TX_CAUSE: assert property (
      $changed(TX_PARAM) |-> $past(TX_EN, 2) || $past(TX_EN, 3) || $past(TX_EN, 4))
      else $error("tx shadow changed without tx enable");
   AST_RX_CAUSE: assert property (
      $changed(RX_PARAM) |-> $past(RX_EN, 2) || $past(RX_EN, 3) || $past(RX_EN, 4))
      else $error("rx shadow changed without rx enable");
   AST_TX_HOLD: assert property (
      up == 5'h1f && TX_EN && $past(TX_EN, 16) |-> $stable(TX_PARAM))
      else $error("tx shadow changed mid frame");
   AST_RX_HOLD: assert property (
      up == 5'h1f && RX_EN && $past(RX_EN, 16) && PHY_ACTIVITY_IND && $past(PHY_ACTIVITY_IND, 2)
      |-> $stable(RX_PARAM))
      else $error("rx shadow changed mid frame");
endmodule
bind mpfc_frame_param_ctrl mpfc_checker i_mpfc_checker (
   .CLK_SYS(CLK_SYS),
   .RST_N(RST_N),
   .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BVALID(S_AXI_BVALID),
   .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RVALID(S_AXI_RVALID),
   .S_AXI_RREADY(S_AXI_RREADY),
   .TX_EN(TX_EN),
   .RX_EN(RX_EN),
   .PHY_ACTIVITY_IND(PHY_ACTIVITY_IND),
   .TX_PARAM(TX_PARAM),
   .RX_PARAM(RX_PARAM),
   .TONE_IDX(TONE_IDX),
   .TONE_MASK(TONE_MASK)
);

// ==== tb/mpfc_mac_model.sv ====
`timescale 1ns/1ns
module mpfc_mac_model (
   input wire logic tx_want,
   input wire logic rx_want,
   output logic pclk,
   output logic tx_en,
   output logic rx_en
);
   // link clock runs free at one eighth of the system clock, each rise 12 ns after a system clock rise
   initial begin
      pclk = 1'b0;
      tx_en = 1'b0;
      rx_en = 1'b0;
      #37;
      forever #200 pclk = ~pclk;
   end
   // enables move at a link rise only after the bench has set the registers
   always @(posedge pclk) begin
      tx_en <= tx_want;
      rx_en <= rx_want;
   end
endmodule

// ==== tb/mpfc_frame_param_ctrl_bench.sv ====
`timescale 1ns/1ns
module mpfc_frame_param_ctrl_bench;
   logic clk, rst_n, awv, wv, bre, arv, rre, tx_want, rx_want, pclk, tx_en, rx_en, act;
   logic awr, wr_rdy, bv, arr, rv;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdat;
   logic [1:0] bresp, rresp;
   logic [5:0] tidx;
   logic [7:0] tmask;
   mpfc_pkg::mpfc_rx_hdr_s hdr;
   mpfc_pkg::mpfc_tx_param_s txp;
   mpfc_pkg::mpfc_rx_param_s rxp;
   int n_fail, samples_checked;

   mpfc_frame_param_ctrl i_mpfc_frame_param_ctrl (
      .CLK_SYS(clk), .RST_N(rst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
      .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre),
      .PCLK(pclk), .TX_EN(tx_en), .RX_EN(rx_en), .PHY_ACTIVITY_IND(act), .RX_HDR(hdr),
      .TX_PARAM(txp), .RX_PARAM(rxp), .TONE_IDX(tidx), .TONE_MASK(tmask)
   );
   mpfc_mac_model i_mpfc_mac_model (
      .tx_want(tx_want), .rx_want(rx_want), .pclk(pclk), .tx_en(tx_en), .rx_en(rx_en)
   );

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                     input logic [1:0] er = mpfc_pkg::RESP_OKAY);
      logic done;
      done = 1'b0;
      @(posedge clk);
      awaddr <= {2'b00, idx, 2'b00};
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bre <= 1'b1;
      for (int n = 0; n < 40 && !done; n++) begin
         @(posedge clk);
         if (awv && awr) awv <= 1'b0;
         if (wv && wr_rdy) wv <= 1'b0;
         if (bv) begin
            done = 1'b1;
            bre <= 1'b0;
            chk({30'h0, bresp}, {30'h0, er});
         end
      end
      if (!done) chk(32'hdead, 32'h0);
      if (!done) print_verdict();
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] exp,
                     input logic [1:0] er = mpfc_pkg::RESP_OKAY);
      logic done;
      done = 1'b0;
      @(posedge clk);
      araddr <= {2'b00, idx, 2'b00};
      arv <= 1'b1;
      rre <= 1'b1;
      for (int n = 0; n < 40 && !done; n++) begin
         @(posedge clk);
         if (arv && arr) arv <= 1'b0;
         if (rv) begin
            done = 1'b1;
            rre <= 1'b0;
            chk({30'h0, rresp}, {30'h0, er});
            if (er == mpfc_pkg::RESP_OKAY) chk(rdat, exp);
         end
      end
      if (!done) chk(32'hdead, 32'h0);
      if (!done) print_verdict();
   endtask
   task automatic tone(input logic [5:0] idx, input logic [7:0] exp);
      @(posedge clk) tidx <= idx;
      cyc(2);
      chk({24'h0, tmask}, {24'h0, exp});
   endtask
   // one received frame; next settings land before activity falls
   task automatic frame(input logic [7:0] ctl, input logic pre, input logic [4:0] rate);
      @(posedge clk) act <= 1'b1;
      // header as the far MAC built it: valid and burst set, preamble and rate as given
      hdr <= {1'b1, 1'b1, pre, rate};
      @(posedge clk) hdr <= '0;
      wr(mpfc_pkg::IDX_RX_CONTROL, {24'h0, ctl});
      @(posedge clk) act <= 1'b0;
      cyc(4);
   endtask

   initial begin
      {rst_n, awv, wv, bre, arv, rre, tx_want, rx_want, act} = '0;
      {awaddr, araddr, wdata} = '0;
      hdr = '0;
      tidx = 6'h3f;
      n_fail = 0;
      samples_checked = 0;
      cyc(2);
      rst_n <= 1'b1;
      rd(mpfc_pkg::IDX_TX_CHANNEL, 32'h0);
      rd(mpfc_pkg::IDX_TX_CONTROL, 32'h0);
      rd(mpfc_pkg::IDX_RX_CHANNEL, 32'h0);
      rd(mpfc_pkg::IDX_RX_CONTROL, 32'h0);
      rd(mpfc_pkg::IDX_BURST_CTL, 32'h0);
      rd(mpfc_pkg::IDX_TONE_PTR, 32'h0);
      rd(mpfc_pkg::IDX_TONE_DATA, 32'hff);
      rd(mpfc_pkg::IDX_TONE_PTR, 32'h1);
      rd(8'h3f, 32'h0, mpfc_pkg::RESP_DECERR);
      wr(8'h3f, 32'h0, mpfc_pkg::RESP_DECERR);
      tone(6'h3f, 8'hff);
      $display("test reset done");
      wr(mpfc_pkg::IDX_TX_CHANNEL, 32'hff);
      rd(mpfc_pkg::IDX_TX_CHANNEL, 32'h7f);
      wr(mpfc_pkg::IDX_TX_CONTROL, 32'hff);
      rd(mpfc_pkg::IDX_TX_CONTROL, 32'hfd);
      wr(mpfc_pkg::IDX_RX_CONTROL, 32'hff);
      rd(mpfc_pkg::IDX_RX_CONTROL, 32'h0f);
      $display("test registers done");
      wr(mpfc_pkg::IDX_TONE_PTR, 32'h2f);
      wr(mpfc_pkg::IDX_TONE_DATA, 32'h5a);
      rd(mpfc_pkg::IDX_TONE_PTR, 32'h0);
      wr(mpfc_pkg::IDX_TONE_DATA, 32'ha5);
      tone(6'h2f, 8'h5a);
      tone(6'h00, 8'ha5);
      wr(mpfc_pkg::IDX_TONE_PTR, 32'h2f);
      rd(mpfc_pkg::IDX_TONE_DATA, 32'h5a);
      rd(mpfc_pkg::IDX_TONE_PTR, 32'h0);
      wr(mpfc_pkg::IDX_TONE_PTR, 32'h60);
      tone(6'h2f, 8'hff);
      tone(6'h00, 8'ha5);
      wr(mpfc_pkg::IDX_TONE_PTR, 32'h70);
      tone(6'h00, 8'hff);
      rd(mpfc_pkg::IDX_TONE_PTR, 32'h30);
      $display("test tone map done");
      wr(mpfc_pkg::IDX_TX_CHANNEL, 32'h15);
      wr(mpfc_pkg::IDX_TX_CONTROL, 32'h41);
      @(posedge clk) tx_want <= 1'b1;
      cyc(24);
      chk({16'h0, txp}, 32'h1541);
      wr(mpfc_pkg::IDX_TX_CHANNEL, 32'h2a);
      cyc(24);
      chk({16'h0, txp}, 32'h1541);
      @(posedge clk) tx_want <= 1'b0;
      cyc(24);
      @(posedge clk) tx_want <= 1'b1;
      cyc(24);
      chk({16'h0, txp}, 32'h2a41);
      $display("test tx capture done");
      wr(mpfc_pkg::IDX_RX_CHANNEL, 32'h33);
      wr(mpfc_pkg::IDX_RX_CONTROL, 32'h03);
      @(posedge clk) rx_want <= 1'b1;
      cyc(24);
      chk({15'h0, rxp}, {15'h0, 8'h33, 8'h03, 1'b1});
      wr(mpfc_pkg::IDX_BURST_CTL, 32'h1);
      rd(mpfc_pkg::IDX_BURST_CTL, 32'h1);
      wr(mpfc_pkg::IDX_RX_CHANNEL, 32'h44);
      frame(8'h03, 1'b0, 5'h0b);
      chk({15'h0, rxp}, {15'h0, 8'h44, 8'h03, 1'b0});
      rd(mpfc_pkg::IDX_RX_HDR_STAT, 32'h4b);
      frame(8'h01, 1'b0, 5'h12);
      chk({15'h0, rxp}, {15'h0, 8'h44, 8'h01, 1'b1});
      rd(mpfc_pkg::IDX_RX_HDR_STAT, 32'hd2);
      @(posedge clk) rx_want <= 1'b0;
      cyc(24);
      frame(8'h03, 1'b0, 5'h13);
      chk({15'h0, rxp}, {15'h0, 8'h44, 8'h01, 1'b1});
      rd(mpfc_pkg::IDX_RX_HDR_STAT, 32'h53);
      @(posedge clk) rx_want <= 1'b1;
      cyc(24);
      chk({15'h0, rxp}, {15'h0, 8'h44, 8'h03, 1'b1});
      rd(mpfc_pkg::IDX_FRAME_STAT, 32'h0003_0341);
      $display("test rx capture done");
      print_verdict();
   end
endmodule
